// ==== hdl/fbi_pkg.sv ====
package fbi_pkg;

   localparam int unsigned DATA_W        = 16;
   localparam int unsigned ADDR_LSB      = 1;
   localparam int unsigned ADDR_PIN_MSB  = 25;
   localparam int unsigned ADDR_PIN_W    = ADDR_PIN_MSB - ADDR_LSB + 1;
   localparam int unsigned PEND_POL_BIT  = 10;
   localparam int unsigned TOP_DIE_BIT   = 25;
   localparam int unsigned SYNC_STAGES   = 2;

   localparam int unsigned DENS_64M      = 64;
   localparam int unsigned DENS_128M     = 128;
   localparam int unsigned DENS_256M     = 256;
   localparam int unsigned DENS_512M     = 512;
   localparam int unsigned MSB_64M       = 22;
   localparam int unsigned MSB_128M      = 23;
   localparam int unsigned MSB_256M      = 24;
   localparam int unsigned MSB_512M      = 25;

   localparam logic [DATA_W-1:0]     RCR_RESET  = 16'h0000;
   localparam logic [ADDR_PIN_W-1:0] ADDR_RESET = 25'h0000000;
   localparam logic [DATA_W-1:0]     DATA_RESET = 16'h0000;

   typedef enum logic [1:0] {
      FBI_SRC_ARRAY,
      FBI_SRC_STATUS,
      FBI_SRC_PROT,
      FBI_SRC_RCR
   } fbi_src_t;

   typedef enum logic {
      FBI_MODE_ASYNC,
      FBI_MODE_SYNC
   } fbi_mode_t;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic address_valid_n;
      logic bus_clk;
      logic reset_pin_n;
   } fbi_ctl_t;

   typedef struct packed {
      logic [ADDR_PIN_W-1:0] addr;
      logic [DATA_W-1:0]     data;
   } fbi_wr_t;

endpackage : fbi_pkg

// ==== hdl/fbi_sync.sv ====
`timescale 1ns/1ns
module fbi_sync #(
   parameter int unsigned   WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= RST_VAL;
         q      <= RST_VAL;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule : fbi_sync

// ==== hdl/fbi_bus_if.sv ====
`timescale 1ns/1ns
// Behaviour
// [R1] sync read: address at strobe rise or clock
// [R2] async: strobe rise latches, low flows through
// [R3] host ties unused address strobe low
// [R4] host ties unused bus clock steady
// [R5] data bus: writes in, reads source out
// [R6] data float when select or enable high
// [R7] write strobe rise latches address and data
// [R8] low select activates die logic
// [R9] high select: standby, data and pending float
// [R10] host deselects when idle
// [R11] output enable drives data, else float
// [R12] reset pin resets automation, blocks writes
// [R13] reset exit gives async array read
// [R14] pending polarity from configuration bit ten
// [R15] sync read: pending while data invalid
// [R16] async page and writes: pending deasserted
// [R17] pending driven only when both selected
// [R18] address width follows density
// [R19] 512 Mbit: top bit selects top die
// [R20] address bit one is word granular
module fbi_bus_if
   import fbi_pkg::*;
#(
   parameter int unsigned DENSITY_MBIT = DENS_512M
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire fbi_ctl_t              ctl_pin,
   input  wire logic [ADDR_PIN_W-1:0] addr_pin,
   input  wire logic [DATA_W-1:0]     dq_in,
   output logic      [DATA_W-1:0]     dq_out,
   output logic                       dq_oe,
   output logic                       pending_out,
   output logic                       pending_oe,
   input  wire logic [DATA_W-1:0]     array_rdata,
   input  wire logic                  array_rvalid,
   input  wire logic [DATA_W-1:0]     status_rdata,
   input  wire logic [DATA_W-1:0]     prot_rdata,
   input  wire logic                  src_load,
   input  wire fbi_src_t              src_sel,
   input  wire logic                  mode_load,
   input  wire fbi_mode_t             mode_sel,
   input  wire logic                  rcr_load,
   input  wire logic [DATA_W-1:0]     rcr_data,
   output logic      [ADDR_PIN_W-1:0] array_addr,
   output logic                       top_die_sel,
   output logic                       die_active,
   output logic                       standby,
   output logic                       automation_rst,
   output logic                       wr_req,
   output fbi_wr_t                    wr_info,
   output logic [DATA_W-1:0]          read_configuration_register
);

   function automatic int unsigned msb_of(input int unsigned dens);
      case (dens)
         DENS_64M:  msb_of = MSB_64M;
         DENS_128M: msb_of = MSB_128M;
         DENS_256M: msb_of = MSB_256M;
         default:   msb_of = MSB_512M;
      endcase
   endfunction : msb_of

   localparam int unsigned ADDR_MSB = msb_of(DENSITY_MBIT);
   localparam int unsigned ADDR_W   = ADDR_MSB - ADDR_LSB + 1;

   function automatic logic [ADDR_PIN_W-1:0] mask_addr(
      input logic [ADDR_PIN_W-1:0] a
   );
      logic [ADDR_PIN_W-1:0] m;
      m = '0;
      m[ADDR_W-1:0] = a[ADDR_W-1:0];
      mask_addr = m;
   endfunction : mask_addr

   fbi_ctl_t              ctl_s;
   logic [ADDR_PIN_W-1:0] addr_s;
   logic [DATA_W-1:0]     dq_s;
   fbi_ctl_t              ctl_d_r;

   fbi_sync #(
      .WIDTH   ($bits(fbi_ctl_t)),
      .RST_VAL ('1)
   ) u_sync_ctl (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       (ctl_pin),
      .q       (ctl_s)
   );

   fbi_sync #(
      .WIDTH (ADDR_PIN_W)
   ) u_sync_addr (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       (addr_pin),
      .q       (addr_s)
   );

   fbi_sync #(
      .WIDTH (DATA_W)
   ) u_sync_dq (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       (dq_in),
      .q       (dq_s)
   );

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctl_d_r <= '1;
      end else begin
         ctl_d_r <= ctl_s;
      end
   end

   logic in_reset;
   logic adv_rise;
   logic adv_fall;
   logic bclk_rise;
   logic we_rise;
   logic selected;
   logic reading;

   assign in_reset  = !ctl_s.reset_pin_n;
   assign adv_rise  = ctl_s.address_valid_n && !ctl_d_r.address_valid_n;
   assign adv_fall  = !ctl_s.address_valid_n && ctl_d_r.address_valid_n;
   assign bclk_rise = ctl_s.bus_clk && !ctl_d_r.bus_clk;
   assign we_rise   = ctl_s.we_n && !ctl_d_r.we_n;
   assign selected  = !ctl_s.ce_n;
   assign reading   = selected && !ctl_s.oe_n && ctl_s.we_n;

   // mode and read source
   fbi_mode_t mode_r;
   fbi_src_t  src_r;
   logic [DATA_W-1:0] rcr_r;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= FBI_MODE_ASYNC;
      end else if (in_reset) begin
         mode_r <= FBI_MODE_ASYNC; // see [R13]
      end else if (mode_load) begin
         mode_r <= mode_sel;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         src_r <= FBI_SRC_ARRAY;
      end else if (in_reset) begin
         src_r <= FBI_SRC_ARRAY; // see [R13]
      end else if (src_load) begin
         src_r <= src_sel;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rcr_r <= RCR_RESET;
      end else if (in_reset) begin
         rcr_r <= RCR_RESET;
      end else if (rcr_load) begin
         rcr_r <= rcr_data;
      end
   end

   assign read_configuration_register = rcr_r;

   // address capture
   logic [ADDR_PIN_W-1:0] addr_hold_r;
   logic                  sync_taken_r;
   logic [ADDR_PIN_W-1:0] addr_nxt;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync_taken_r <= 1'b0;
      end else if (adv_fall || ctl_s.address_valid_n) begin
         sync_taken_r <= 1'b0;
      end else if (mode_r == FBI_MODE_SYNC && bclk_rise) begin
         sync_taken_r <= 1'b1; // see [R1]
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         addr_hold_r <= ADDR_RESET;
      end else if (we_rise && selected) begin
         addr_hold_r <= mask_addr(addr_s); // see [R7]
      end else if (adv_rise && !sync_taken_r) begin
         addr_hold_r <= mask_addr(addr_s); // see [R1] [R2]
      end else if (mode_r == FBI_MODE_SYNC && !sync_taken_r
                   && !ctl_s.address_valid_n && bclk_rise) begin
         addr_hold_r <= mask_addr(addr_s); // see [R1]
      end
   end

   always_comb begin
      addr_nxt = addr_hold_r;
      if (mode_r == FBI_MODE_ASYNC && !ctl_s.address_valid_n) begin
         addr_nxt = mask_addr(addr_s); // see [R2] [R3]
      end
   end

   // word address out, bit one is index zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         array_addr  <= ADDR_RESET;
         top_die_sel <= 1'b0;
      end else begin
         array_addr  <= addr_nxt; // see [R18] [R20]
         if (DENSITY_MBIT == DENS_512M) begin
            top_die_sel <= addr_nxt[TOP_DIE_BIT-ADDR_LSB]; // see [R19]
         end else begin
            top_die_sel <= 1'b0;
         end
      end
   end

   // writes
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_req  <= 1'b0;
         wr_info <= '{addr: ADDR_RESET, data: DATA_RESET};
      end else begin
         wr_req <= we_rise && selected && !in_reset; // see [R7] [R12]
         if (we_rise && selected) begin
            wr_info.addr <= mask_addr(addr_s); // see [R7]
            wr_info.data <= dq_s; // see [R5] [R7]
         end
      end
   end

   // die activity and automation reset
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         die_active     <= 1'b0;
         standby        <= 1'b1;
         automation_rst <= 1'b1;
      end else begin
         die_active     <= selected; // see [R8]
         standby        <= !selected; // see [R9]
         automation_rst <= in_reset; // see [R12]
      end
   end

   // read data path
   logic [DATA_W-1:0] rd_nxt;

   always_comb begin
      case (src_r)
         FBI_SRC_ARRAY:  rd_nxt = array_rdata;
         FBI_SRC_STATUS: rd_nxt = status_rdata;
         FBI_SRC_PROT:   rd_nxt = prot_rdata;
         FBI_SRC_RCR:    rd_nxt = rcr_r;
         default:        rd_nxt = array_rdata;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dq_out <= DATA_RESET;
         dq_oe  <= 1'b0;
      end else begin
         dq_out <= rd_nxt; // see [R5]
         dq_oe  <= reading; // see [R6] [R9] [R11]
      end
   end

   // pending output
   logic pend_active;
   logic pend_pol;

   assign pend_pol    = rcr_r[PEND_POL_BIT];
   assign pend_active = mode_r == FBI_MODE_SYNC && reading
                        && !array_rvalid; // see [R15] [R16]

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pending_out <= 1'b0;
         pending_oe  <= 1'b0;
      end else begin
         pending_out <= pend_active ? pend_pol : !pend_pol; // see [R14]
         pending_oe  <= selected && !ctl_s.oe_n; // see [R17] [R9] [R11]
      end
   end

endmodule : fbi_bus_if

// ==== verif/fbi_monitor.sv ====
`timescale 1ns/1ns
module fbi_monitor
   import fbi_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              rst_n,
   input wire fbi_ctl_t          ctl_pin,
   input wire logic              dq_oe,
   input wire logic              pending_out,
   input wire logic              pending_oe,
   input wire logic              die_active,
   input wire logic              standby,
   input wire logic              automation_rst,
   input wire logic              wr_req,
   input wire logic [DATA_W-1:0] read_configuration_register
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_read;
      !ctl_pin.ce_n && !ctl_pin.oe_n && ctl_pin.we_n;
   endsequence
   sequence s_wr_off;
      ctl_pin.ce_n || !ctl_pin.reset_pin_n;
   endsequence
   a_ce_float: assert property (
      ctl_pin.ce_n[*4] |-> !dq_oe && !pending_oe)
      else $error("outputs driven while deselected");
   a_oe_float: assert property (
      ctl_pin.oe_n[*4] |-> !dq_oe && !pending_oe)
      else $error("outputs driven with output enable high");
   a_read_drive: assert property (
      s_read[*4] |-> dq_oe && pending_oe)
      else $error("outputs not driven in read");
   a_standby_lvl: assert property (
      ctl_pin.ce_n[*4] |-> standby && !die_active)
      else $error("no standby while deselected");
   a_die_on: assert property (
      (!ctl_pin.ce_n)[*4] |-> die_active && !standby)
      else $error("die not active while selected");
   a_auto_rst: assert property (
      (!ctl_pin.reset_pin_n)[*4] |-> automation_rst)
      else $error("automation not reset");
   a_wr_block: assert property (
      s_wr_off[*6] |-> !wr_req)
      else $error("write accepted while blocked");
   a_wr_pulse: assert property (
      wr_req |=> !wr_req)
      else $error("write request longer than one cycle");
   a_pend_write: assert property (
      (!ctl_pin.we_n)[*4] ##0 $stable(read_configuration_register)
      |-> pending_out != read_configuration_register[PEND_POL_BIT])
      else $error("pending asserted in write");
endmodule : fbi_monitor

bind fbi_bus_if fbi_monitor u_mon (.clk_sys, .rst_n, .ctl_pin, .dq_oe,
   .pending_out, .pending_oe, .die_active, .standby, .automation_rst,
   .wr_req, .read_configuration_register);

// ==== verif/fbi_host.sv ====
`timescale 1ns/1ns
module fbi_host
   import fbi_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic [DATA_W-1:0]     dq_out,
   input  wire logic                  dq_oe,
   output fbi_ctl_t                   ctl_pin,
   output logic      [ADDR_PIN_W-1:0] addr_pin,
   output logic      [DATA_W-1:0]     dq_in
);
   logic [DATA_W-1:0] hd_r;
   logic              hoe_r;
   // released bus shows inverse of last host word
   assign dq_in = dq_oe ? dq_out : (hoe_r ? hd_r : ~hd_r);
   initial begin
      ctl_pin  = 6'h39; // idle, strobe low
      addr_pin = '0;
      hd_r     = '0;
      hoe_r    = 1'b0;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   task automatic sel(input logic [ADDR_PIN_W-1:0] a);
      addr_pin     = a;
      ctl_pin.ce_n = 1'b0;
      ctl_pin.oe_n = 1'b0;
      cyc(6);
   endtask : sel
   task automatic desel();
      ctl_pin = {5'b11100, ctl_pin.reset_pin_n};
      cyc(6);
   endtask : desel
   task automatic wr(input logic [ADDR_PIN_W-1:0] a,
                     input logic [DATA_W-1:0] d, input int n);
      hd_r         = d;
      hoe_r        = 1'b1;
      addr_pin     = a;
      ctl_pin.ce_n = 1'b0;
      cyc(n);
      ctl_pin.we_n = 1'b0;
      cyc(n);
      ctl_pin.we_n = 1'b1;
      cyc(n);
      hoe_r = 1'b0;
      desel();
   endtask : wr
   task automatic strobe(input logic v);
      ctl_pin.address_valid_n = v;
      cyc(6);
   endtask : strobe
   task automatic bclk();
      ctl_pin.bus_clk = 1'b1; // pulses only inside reads
      cyc(3);
      ctl_pin.bus_clk = 1'b0;
      cyc(3);
   endtask : bclk
   task automatic rpin(input logic v);
      ctl_pin.reset_pin_n = v;
      cyc(6);
   endtask : rpin
endmodule : fbi_host

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
module tb_top
   import fbi_pkg::*;
;
   typedef struct packed {
      fbi_src_t          s;
      logic [DATA_W-1:0] e;
   } fbi_row_t;
   logic                  clk_sys, rst_n, dq_oe, pending_out, pending_oe;
   logic                  array_rvalid, src_load, mode_load, rcr_load;
   logic                  top_die_sel, die_active, standby, automation_rst;
   logic                  wr_req;
   logic [DATA_W-1:0]     dq_in, dq_out, rcr_data, read_configuration_register;
   logic [ADDR_PIN_W-1:0] addr_pin, array_addr;
   logic [3:0]            nwr;
   logic [DATA_W-1:0]     array_rdata, status_rdata, prot_rdata;
   fbi_ctl_t              ctl_pin;
   fbi_src_t              src_sel;
   fbi_mode_t             mode_sel;
   fbi_wr_t               wr_info, wb;
   int                    fails, check_count, cyc_n;
   fbi_row_t rows [4] = '{'{FBI_SRC_ARRAY, 16'h1234},
      '{FBI_SRC_STATUS, 16'h0080}, '{FBI_SRC_PROT, 16'h5a5a},
      '{FBI_SRC_RCR, 16'h0400}};
   fbi_host u_host (.clk_sys, .dq_out, .dq_oe, .ctl_pin, .addr_pin, .dq_in);
   fbi_bus_if u_dut (.clk_sys, .rst_n, .ctl_pin, .addr_pin, .dq_in, .dq_out,
      .dq_oe, .pending_out, .pending_oe, .array_rdata,
      .array_rvalid, .status_rdata, .prot_rdata,
      .src_load, .src_sel, .mode_load, .mode_sel, .rcr_load, .rcr_data,
      .array_addr, .top_die_sel, .die_active, .standby, .automation_rst,
      .wr_req, .wr_info, .read_configuration_register);
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) begin
      cyc_n++;
      if (wr_req === 1'b1) begin
         nwr = nwr + 4'h1;
         wb  = wr_info;
      end
      if (cyc_n == 3000) begin
         fails++;
         conclude();
      end
   end
   task automatic ck(input logic [24:0] g, input logic [24:0] e);
      check_count++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : ck
   task automatic cfg(input fbi_src_t s, input fbi_mode_t m,
                      input logic [DATA_W-1:0] r);
      {src_sel, mode_sel, rcr_data} = {s, m, r};
      {src_load, mode_load, rcr_load} = 3'h7;
      @(negedge clk_sys);
      {src_load, mode_load, rcr_load} = 3'h0;
      repeat (6) @(negedge clk_sys);
   endtask : cfg
   task automatic conclude();
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   initial begin
      {cyc_n, fails, check_count, nwr} = '0;
      {rst_n, array_rvalid, src_load, mode_load, rcr_load} = 5'h00;
      {src_sel, mode_sel, rcr_data} = {FBI_SRC_ARRAY, FBI_MODE_ASYNC, 16'h0};
      array_rdata  = 16'h1234;
      status_rdata = 16'h0080;
      prot_rdata   = 16'h5a5a;
      repeat (8) @(negedge clk_sys);
      ck(standby, 1'b1);
      ck(dq_oe, 1'b0);
      rst_n = 1'b1;
      repeat (6) @(negedge clk_sys);
      ck(automation_rst, 1'b0);
      for (int i = 0; i < 4; i++) begin
         cfg(rows[i].s, FBI_MODE_ASYNC, 16'h0400);
         u_host.sel(25'h0000002);
         ck(dq_out, rows[i].e);
         ck(die_active, 1'b1);
         u_host.desel();
      end
      $display("sources done");
      u_host.wr(25'h1000001, 16'hbeef, 2);
      ck(wb.addr, 25'h1000001);
      ck(wb.data, 16'hbeef);
      u_host.wr(25'h0000001, 16'h0001, 8);
      ck(nwr, 4'h2);
      u_host.sel(25'h1000003);
      ck(array_addr, 25'h1000003);
      ck(top_die_sel, 1'b1);
      u_host.strobe(1'b1);
      u_host.sel(25'h0000005);
      ck(array_addr, 25'h1000003);
      u_host.desel();
      $display("writes and address done");
      cfg(FBI_SRC_ARRAY, FBI_MODE_SYNC, 16'h0000);
      u_host.sel(25'h0000010);
      u_host.bclk();
      u_host.sel(25'h0000020);
      ck(array_addr, 25'h0000010);
      ck(pending_out, 1'b0);
      cfg(FBI_SRC_ARRAY, FBI_MODE_SYNC, 16'h0400);
      ck(pending_out, 1'b1);
      array_rvalid = 1'b1;
      repeat (6) @(negedge clk_sys);
      ck(pending_out, 1'b0);
      array_rvalid = 1'b0;
      cfg(FBI_SRC_ARRAY, FBI_MODE_ASYNC, 16'h0400);
      ck(pending_out, 1'b0);
      ck(pending_oe, 1'b1);
      $display("pending done");
      cfg(FBI_SRC_STATUS, FBI_MODE_SYNC, 16'h0400);
      u_host.desel();
      u_host.rpin(1'b0);
      ck(automation_rst, 1'b1);
      ck(read_configuration_register, 16'h0);
      u_host.wr(25'h0000007, 16'h0007, 2);
      ck(nwr, 4'h2);
      u_host.rpin(1'b1);
      array_rdata = 16'h4321;
      u_host.sel(25'h0000008);
      ck(dq_out, 16'h4321);
      ck(pending_out, 1'b1);
      u_host.desel();
      ck(pending_oe, 1'b0);
      ck(standby, 1'b1);
      $display("reset pin done");
      conclude();
   end
endmodule : tb_top
